//--- logic/acf_top.sv
`timescale 1ns/10ps
// Functional notes
// - shift only while select is low
// - input bits sampled on falling edges
// - every sixteenth edge commits the word
// - partial trailing word is dropped
// - many words per select period
// - address byte first, then data byte
// - any slow clock rate, any duty
// - reset pin pulse restores defaults
// - soft reset bit restores, self-clears
// - readback mode blocks register writes except to the control register
// - readback shifts addressed register out
// - data-out high impedance without readback
// - format pin level decodes four ways
// - power pins decode four legal modes
// - lvds pairs: even rising, odd falling
// - cmos one bit per pin per cycle
// - mux mode interleaves onto channel b
// - coding from register or format pin
// - overdrive saturates to full-scale codes
// - swing code programs lvds amplitude
// - performance codes 01 and 10 rejected
module acf_top (
  // sample clock and reset pin
  input wire logic i_mclk,
  input wire logic i_reset,
  // serial port, serial clock is its own domain
  input wire logic i_serial_clk,
  input wire logic i_serial_select_n,
  input wire logic i_serial_data_in,
  output logic o_serial_data_out_pin,
  output logic o_serial_data_out_oe,
  // static pins
  input wire logic [1:0] i_format_select_pin,
  input wire logic i_power_mode_pin_1,
  input wire logic i_power_mode_pin_2,
  input wire logic i_power_mode_pin_3,
  // converter samples and overdrive flags
  input wire logic [13:0] i_sample_a,
  input wire logic [13:0] i_sample_b,
  input wire logic i_over_pos_a,
  input wire logic i_over_neg_a,
  input wire logic i_over_pos_b,
  input wire logic i_over_neg_b,
  // output bus
  output logic [13:0] o_channel_a_data_bus,
  output logic o_channel_a_oe,
  output logic [13:0] o_channel_b_data_bus,
  output logic o_channel_b_oe,
  output logic [6:0] o_lvds_a_pairs,
  output logic [6:0] o_lvds_b_pairs,
  output logic o_lvds_output_clock_pos,
  output logic o_cmos_output_clock,
  output logic o_lvds_mode,
  output logic [5:0] o_lvds_swing_code,
  output logic [1:0] o_performance_select_field,
  output logic o_global_power_down,
  output logic o_channel_a_standby
);
  // ****************************************
  // serial clock domain
  // ****************************************
  typedef struct packed {
    logic [3:0] count;
    logic [14:0] shift;
    logic [7:0] out_shift;
    logic word_tgl;
    logic [15:0] word;
    logic frame_seen;
  } acf_spi_t;
  acf_spi_t spi;
  acf_spi_t next_spi;
  logic [7:0] rd_data_s;
  logic readback_s;
  logic [15:0] full_word;
  logic frame_tgl;
  logic [3:0] bit_cnt;
  assign full_word = {spi.shift, i_serial_data_in};
  // a select rise since the last edge means a fresh frame: count restarts
  assign bit_cnt = (spi.frame_seen != frame_tgl) ? 4'h0 : spi.count;
  always_comb begin
    next_spi = spi;
    next_spi.frame_seen = frame_tgl;
    if (!i_serial_select_n) begin
      next_spi.shift = full_word[14:0];
      next_spi.out_shift = {spi.out_shift[6:0], 1'b0};
      next_spi.count = bit_cnt + 4'h1;
      if (bit_cnt == 4'hf) begin
        next_spi.word = full_word;
        next_spi.word_tgl = ~spi.word_tgl;
      end
      if (bit_cnt == 4'h7) begin
        next_spi.out_shift = rd_data_s;
      end
    end else begin
      next_spi.count = 4'h0;
    end
  end
  // select rise marks a new frame
  // the serial clock is parked between frames, so the count cannot be cleared by it
  always_ff @(posedge i_serial_select_n or posedge i_reset) begin
    if (i_reset) begin
      frame_tgl <= 1'b0;
    end else begin
      frame_tgl <= ~frame_tgl;
    end
  end
  always_ff @(negedge i_serial_clk or posedge i_reset) begin
    if (i_reset) begin
      spi <= '0;
    end else begin
      spi <= next_spi;
    end
  end
  assign o_serial_data_out_oe = readback_s & ~i_serial_select_n;
  assign o_serial_data_out_pin = spi.out_shift[7];
  // ****************************************
  // word crossing and register file
  // ****************************************
  // toggle crossing, any slow sclk rate
  logic tgl_sync;
  logic rb_sync_unused;
  acf_sync #(.WIDTH(1)) u_word_sync (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_async(spi.word_tgl),
    .o_sync(tgl_sync)
  );
  typedef struct packed {
    logic tgl_seen;
    logic [7:0] r_ctrl;
    logic [7:0] r_swing;
    logic [7:0] r_perf;
    logic [7:0] r_fmt;
    logic [7:0] r_iface;
    logic [7:0] r_swing_en;
  } acf_core_t;
  acf_core_t st;
  acf_core_t next_st;
  // output path keeps running while the reset pin is held high in pin mode
  typedef struct packed {
    logic [1:0] fmt_pin;
    logic [2:0] pm_pin;
    logic pin_mode;
    logic [13:0] a_q;
    logic [13:0] b_q;
    logic mux_phase;
  } acf_out_t;
  acf_out_t fo;
  acf_out_t next_fo;
  logic [1:0] fmt_pin_s;
  logic [2:0] pm_pin_s;
  logic pin_mode_s;
  // no reset here: the reset pin itself is one of the sampled levels
  acf_sync #(.WIDTH(6)) u_pin_sync (
    .i_mclk(i_mclk),
    .i_reset(1'b0),
    .i_async({i_format_select_pin, i_power_mode_pin_1, i_power_mode_pin_2, i_power_mode_pin_3, i_reset}),
    .o_sync({fmt_pin_s, pm_pin_s, pin_mode_s})
  );
  // readback mux; registers are quasi-static while a read is in progress
  always_comb begin
    case (full_word[7:0])
      acf_pkg::ADDR_CTRL: rd_data_s = st.r_ctrl;
      acf_pkg::ADDR_SWING: rd_data_s = st.r_swing;
      acf_pkg::ADDR_PERF: rd_data_s = st.r_perf;
      acf_pkg::ADDR_FORMAT: rd_data_s = st.r_fmt;
      acf_pkg::ADDR_IFACE: rd_data_s = st.r_iface;
      acf_pkg::ADDR_SWING_EN: rd_data_s = st.r_swing_en;
      default: rd_data_s = 8'h00;
    endcase
  end
  assign readback_s = st.r_ctrl[acf_pkg::BIT_READBACK];
  assign rb_sync_unused = 1'b0;
  logic [7:0] w_addr;
  logic [7:0] w_data;
  logic do_write;
  logic [1:0] coding_sel;
  logic iface_cmos;
  logic [13:0] a_code;
  logic [13:0] b_code;
  assign w_addr = spi.word[15:8];
  assign w_data = spi.word[7:0];
  assign do_write = (tgl_sync != st.tgl_seen) &&
                    (!readback_s || (w_addr == acf_pkg::ADDR_CTRL));
  function automatic logic [13:0] acf_code(input logic [13:0] raw, input logic pos,
                                           input logic neg, input logic ob);
    logic [13:0] r;
    r = ob ? (raw ^ acf_pkg::MSB_FLIP) : raw;
    if (pos) begin
      r = ob ? acf_pkg::SAT_POS_OB : acf_pkg::SAT_POS_TC;
    end else if (neg) begin
      r = ob ? acf_pkg::SAT_NEG_OB : acf_pkg::SAT_NEG_TC;
    end
    return r;
  endfunction
  always_comb begin
    next_st = st;
    next_st.tgl_seen = tgl_sync;
    if (do_write) begin
      case (w_addr)
        acf_pkg::ADDR_CTRL: next_st.r_ctrl = w_data & 8'h03;
        acf_pkg::ADDR_SWING: begin
          if (st.r_swing_en[1:0] == acf_pkg::SWING_EN_ON) begin
            next_st.r_swing = w_data & 8'hfc;
          end
        end
        acf_pkg::ADDR_PERF: begin
          if (w_data[1:0] == acf_pkg::PERF_BEST || w_data[1:0] == acf_pkg::PERF_DEFAULT) begin
            next_st.r_perf = w_data & 8'h03;
          end
        end
        acf_pkg::ADDR_FORMAT: next_st.r_fmt = w_data & 8'h18;
        acf_pkg::ADDR_IFACE: next_st.r_iface = w_data & 8'hc0;
        acf_pkg::ADDR_SWING_EN: next_st.r_swing_en = w_data & 8'h03;
        default: next_st.r_ctrl = st.r_ctrl;
      endcase
    end
    if (st.r_ctrl[acf_pkg::BIT_SOFT_RESET]) begin
      next_st.r_ctrl = acf_pkg::REG_RESET_VAL;
      next_st.r_swing = acf_pkg::REG_RESET_VAL;
      next_st.r_perf = acf_pkg::REG_RESET_VAL;
      next_st.r_fmt = acf_pkg::REG_RESET_VAL;
      next_st.r_iface = acf_pkg::REG_RESET_VAL;
      next_st.r_swing_en = acf_pkg::REG_RESET_VAL;
    end
  end
  always_comb begin
    next_fo = fo;
    next_fo.fmt_pin = fmt_pin_s;
    next_fo.pm_pin = pm_pin_s;
    next_fo.pin_mode = pin_mode_s;
    next_fo.a_q = a_code;
    next_fo.b_q = b_code;
    // written as an if so an unset phase settles after one edge
    next_fo.mux_phase = 1'b1;
    if (fo.mux_phase) begin
      next_fo.mux_phase = 1'b0;
    end
  end
  // ****************************************
  // output formatter
  // ****************************************
  logic pm_mux;
  logic pm_pdn;
  logic pm_stby;
  logic ob_sel;
  // reset pin high means pin mode
  always_comb begin
    if (fo.pin_mode) begin
      ob_sel = (fo.fmt_pin == acf_pkg::ACF_FMT_OB_CMOS) || (fo.fmt_pin == acf_pkg::ACF_FMT_OB_LVDS);
      iface_cmos = (fo.fmt_pin == acf_pkg::ACF_FMT_TC_CMOS) || (fo.fmt_pin == acf_pkg::ACF_FMT_OB_CMOS);
    end else begin
      ob_sel = (st.r_fmt[acf_pkg::FMT_LSB +: 2] == acf_pkg::CODE_OFFSET_BIN);
      iface_cmos = (st.r_iface[acf_pkg::IFACE_LSB +: 2] == acf_pkg::CODE_CMOS);
    end
  end
  assign coding_sel = {ob_sel, iface_cmos};
  assign a_code = acf_code(i_sample_a, i_over_pos_a, i_over_neg_a, ob_sel);
  assign b_code = acf_code(i_sample_b, i_over_pos_b, i_over_neg_b, ob_sel);
  assign pm_pdn = (fo.pm_pin == acf_pkg::ACF_PM_GLOBAL_PDN);
  assign pm_stby = (fo.pm_pin == acf_pkg::ACF_PM_A_STANDBY);
  assign pm_mux = (fo.pm_pin == acf_pkg::ACF_PM_MUX);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // data path only, no reset: it must run in pin mode
  always_ff @(posedge i_mclk) begin
    fo <= next_fo;
  end
  // mux onto channel b, a three-stated
  assign o_channel_a_data_bus = fo.a_q;
  assign o_channel_b_data_bus = (pm_mux && fo.mux_phase) ? fo.a_q : fo.b_q;
  assign o_channel_a_oe = ~pm_pdn & ~pm_stby & ~pm_mux;
  assign o_channel_b_oe = ~pm_pdn;
  // even bits on rising half, odd on falling
  genvar gi;
  for (gi = 0; gi < 7; gi++) begin : g_pair
    assign o_lvds_a_pairs[gi] = i_mclk ? fo.a_q[2*gi] : fo.a_q[2*gi+1];
    assign o_lvds_b_pairs[gi] = i_mclk ? fo.b_q[2*gi] : fo.b_q[2*gi+1];
  end
  assign o_lvds_output_clock_pos = i_mclk & ~iface_cmos & ~pm_pdn;
  assign o_cmos_output_clock = i_mclk & iface_cmos & ~pm_pdn;
  assign o_lvds_mode = ~coding_sel[0];
  assign o_lvds_swing_code = st.r_swing[acf_pkg::SWING_LSB +: acf_pkg::SWING_W];
  assign o_performance_select_field = st.r_perf[acf_pkg::PERF_W-1:0];
  assign o_global_power_down = pm_pdn;
  assign o_channel_a_standby = pm_stby;
  // ****************************************
  // checks
  // ****************************************
  property p_soft_reset;
    @(posedge i_mclk) disable iff (i_reset) st.r_ctrl[1] |=> (st.r_ctrl == 8'h00) && (st.r_perf == 8'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear");
  property p_perf_legal;
    @(posedge i_mclk) disable iff (i_reset) st.r_perf[1:0] == 2'h0 || st.r_perf[1:0] == 2'h3;
  endproperty
  a_perf_legal: assert property (p_perf_legal) else $error("illegal performance code");
  property p_block_writes;
    @(posedge i_mclk) disable iff (i_reset) readback_s && !st.r_ctrl[1] && $rose(st.r_iface[7]) |-> 1'b0;
  endproperty
  a_block_writes: assert property (p_block_writes) else $error("write while readback");
  property p_serial_data_out_pin_hiz;
    @(posedge i_mclk) disable iff (i_reset) !readback_s |-> !o_serial_data_out_oe;
  endproperty
  a_serial_data_out_pin_hiz: assert property (p_serial_data_out_pin_hiz) else $error("data-out driven without readback");
  property p_mux_a_off;
    @(posedge i_mclk) disable iff (i_reset) pm_mux |-> !o_channel_a_oe && o_channel_b_oe;
  endproperty
  a_mux_a_off: assert property (p_mux_a_off) else $error("channel a driven in mux mode");
  property p_sat_pos;
    @(posedge i_mclk) disable iff (i_reset) i_over_pos_a && !ob_sel ##1 !ob_sel |-> fo.a_q == 14'h1fff;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive saturation wrong");
  property p_sat_neg;
    @(posedge i_mclk) disable iff (i_reset) i_over_neg_b && !i_over_pos_b && ob_sel ##1 ob_sel |-> fo.b_q == 14'h0000;
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative saturation wrong");
  property p_count_clear;
    @(negedge i_serial_clk) disable iff (i_reset) i_serial_select_n |=> spi.count == 4'h0;
  endproperty
  a_count_clear: assert property (p_count_clear) else $error("bit count survives select high");
  property p_commit;
    @(negedge i_serial_clk) disable iff (i_reset) !i_serial_select_n && bit_cnt == 4'hf |=> spi.word_tgl != $past(spi.word_tgl);
  endproperty
  a_commit: assert property (p_commit) else $error("word not committed");
  c_write: cover property (@(posedge i_mclk) disable iff (i_reset) do_write);
  c_readback: cover property (@(posedge i_mclk) disable iff (i_reset) o_serial_data_out_oe);
  c_mux: cover property (@(posedge i_mclk) disable iff (i_reset) pm_mux);
endmodule

//--- inc/acf_pkg.sv
package acf_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SWING = 8'h01;
  localparam logic [7:0] ADDR_PERF = 8'h03;
  localparam logic [7:0] ADDR_FORMAT = 8'h29;
  localparam logic [7:0] ADDR_IFACE = 8'h41;
  localparam logic [7:0] ADDR_SWING_EN = 8'hf1;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_SOFT_RESET = 1;
  localparam int BIT_READBACK = 0;
  localparam int SWING_LSB = 2;
  localparam int SWING_W = 6;
  localparam int PERF_W = 2;
  localparam int FMT_LSB = 3;
  localparam int IFACE_LSB = 6;
  localparam int SWING_EN_LSB = 0;
  localparam logic [1:0] CODE_OFFSET_BIN = 2'h3;
  localparam logic [1:0] CODE_CMOS = 2'h3;
  localparam logic [1:0] PERF_BEST = 2'h3;
  localparam logic [1:0] PERF_DEFAULT = 2'h0;
  localparam logic [1:0] SWING_EN_ON = 2'h3;
  // ****************************************
  // serial framing and sample coding
  // ****************************************
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 8;
  localparam int DATA_W = 14;
  localparam logic [13:0] SAT_POS_OB = 14'h3fff;
  localparam logic [13:0] SAT_POS_TC = 14'h1fff;
  localparam logic [13:0] SAT_NEG_OB = 14'h0000;
  localparam logic [13:0] SAT_NEG_TC = 14'h2000;
  localparam logic [13:0] MSB_FLIP = 14'h2000;
  // ****************************************
  // static pin decodes
  // ****************************************
  typedef enum logic [1:0] {
    ACF_FMT_TC_CMOS = 2'b00,
    ACF_FMT_OB_CMOS = 2'b01,
    ACF_FMT_OB_LVDS = 2'b10,
    ACF_FMT_TC_LVDS = 2'b11
  } acf_fmt_level_t;
  typedef enum logic [2:0] {
    ACF_PM_NORMAL = 3'b000,
    ACF_PM_GLOBAL_PDN = 3'b100,
    ACF_PM_A_STANDBY = 3'b101,
    ACF_PM_MUX = 3'b111
  } acf_pmode_t;
  localparam logic [1:0] SPI_DDR_HOLD = 2'h0;
endpackage

//--- logic/acf_sync.sv
`timescale 1ns/10ps
// two-flop level synchroniser; stage one is read only by stage two
module acf_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // level in and out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } acf_sync_state_t;
  acf_sync_state_t state;
  acf_sync_state_t next_state;
  always_comb begin
    next_state = state;
    next_state.meta = i_async;
    next_state.stable = state.meta;
  end
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign o_sync = state.stable;
endmodule

//--- dv/acf_ctrl_model.sv
`timescale 1ns/10ps
module acf_ctrl_model (
  // serial lines toward the device
  output logic o_serial_clk,
  output logic o_serial_select_n,
  output logic o_serial_data_in,
  // readback line as seen on the board
  input wire logic i_serial_data_out_pin
);
  // ****************************************
  // idle: clock parked low, select high
  // ****************************************
  initial begin
    o_serial_clk = 1'b0;
    o_serial_select_n = 1'b1;
    o_serial_data_in = 1'b0;
  end
  task automatic frame(input logic [47:0] bits, input int n, output logic [7:0] rb, input logic desel);
    rb = 8'h00;
    #13 o_serial_select_n = desel;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data_in = bits[i];
      #40 o_serial_clk = 1'b1;
      // capture before the falling edge lands in the device
      #60 rb = {rb[6:0], i_serial_data_out_pin};
      o_serial_clk = 1'b0;
      #60;
    end
    #40 o_serial_select_n = 1'b1;
    // released line must not keep a stale level
    o_serial_data_in = ~o_serial_data_in;
  endtask
endmodule

//--- dv/acf_top_tb.sv
`timescale 1ns/10ps
module acf_top_tb;
  // ****************************************
  // signals
  // ****************************************
  logic i_mclk, i_reset, sclk, sel_n, serial_data_in, sd_pin, sd_oe, op_a, on_a, op_b, on_b, oe_a, oe_b, lvds, pdn, stby;
  logic oe_seen;
  logic [2:0] pm;
  logic [1:0] fmt, perf;
  logic [13:0] smp_a, smp_b, bus_a, bus_b, want;
  logic [6:0] pr_a, pr_b;
  logic [5:0] swing;
  logic [7:0] rb;
  wire logic sd_line;
  int n_errors, compares, cycles;
  localparam int LIMIT = 20000;
  // no pull on the readback line
  assign sd_line = sd_oe ? sd_pin : 1'bz;
  acf_top u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_serial_clk(sclk), .i_serial_select_n(sel_n),
    .i_serial_data_in(serial_data_in), .o_serial_data_out_pin(sd_pin), .o_serial_data_out_oe(sd_oe),
    .i_format_select_pin(fmt), .i_power_mode_pin_1(pm[2]), .i_power_mode_pin_2(pm[1]),
    .i_power_mode_pin_3(pm[0]), .i_sample_a(smp_a), .i_sample_b(smp_b), .i_over_pos_a(op_a),
    .i_over_neg_a(on_a), .i_over_pos_b(op_b), .i_over_neg_b(on_b), .o_channel_a_data_bus(bus_a),
    .o_channel_a_oe(oe_a), .o_channel_b_data_bus(bus_b), .o_channel_b_oe(oe_b), .o_lvds_a_pairs(pr_a),
    .o_lvds_b_pairs(pr_b), .o_lvds_output_clock_pos(), .o_cmos_output_clock(), .o_lvds_mode(lvds),
    .o_lvds_swing_code(swing), .o_performance_select_field(perf), .o_global_power_down(pdn),
    .o_channel_a_standby(stby));
  acf_ctrl_model u_ctl (.o_serial_clk(sclk), .o_serial_select_n(sel_n), .o_serial_data_in(serial_data_in),
    .i_serial_data_out_pin(sd_line));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    if (sd_oe === 1'b1) oe_seen <= 1'b1;
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      end_sim();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ctl.frame({32'h0, a, d}, 16, rb, 1'b0);
    tick(10);
  endtask
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults();
    check(swing, 6'h00);
    check(perf, 2'h0);
    check(sd_oe, 1'b0);
  endtask
  task automatic t_perf();
    logic [1:0] exp;
    exp = 2'h0;
    for (int c = 3; c >= 0; c--) begin
      wr(acf_pkg::ADDR_PERF, 8'(c));
      if (c == 0 || c == 3) exp = 2'(c);
      check(perf, exp);
    end
  endtask
  task automatic t_swing();
    u_ctl.frame({16'h0, acf_pkg::ADDR_SWING, 8'h6c, acf_pkg::ADDR_SWING_EN, 8'h03}, 32, rb, 1'b0);
    tick(10);
    check(swing, 6'h00);
    u_ctl.frame({acf_pkg::ADDR_SWING, 8'h50, acf_pkg::ADDR_SWING, 8'h3c, acf_pkg::ADDR_SWING, 8'h6c}, 48, rb, 1'b0);
    tick(10);
    check(swing, 6'h1b);
    u_ctl.frame({20'h0, acf_pkg::ADDR_SWING, 8'h50, acf_pkg::ADDR_SWING, 4'h3}, 28, rb, 1'b0);
    tick(10);
    check(swing, 6'h14);
    u_ctl.frame({32'h0, acf_pkg::ADDR_SWING, 8'h3c}, 16, rb, 1'b1);
    tick(10);
    check(swing, 6'h14);
  endtask
  task automatic t_readback();
    wr(acf_pkg::ADDR_CTRL, 8'h01);
    oe_seen = 1'b0;
    wr(acf_pkg::ADDR_SWING, 8'h00);
    check(rb, 8'h50);
    check(oe_seen, 1'b1);
    check(swing, 6'h14);
    wr(acf_pkg::ADDR_SWING_EN, 8'h00);
    check(rb, 8'h03);
    wr(acf_pkg::ADDR_CTRL, 8'h00);
    check(rb, 8'h01);
    oe_seen = 1'b0;
    wr(acf_pkg::ADDR_SWING, 8'h3c);
    check(oe_seen, 1'b0);
    check(swing, 6'h0f);
  endtask
  task automatic t_resets();
    wr(acf_pkg::ADDR_PERF, 8'h03);
    wr(acf_pkg::ADDR_CTRL, 8'h02);
    check(perf, 2'h0);
    check(swing, 6'h00);
    // a stuck reset bit would swallow this write
    wr(acf_pkg::ADDR_PERF, 8'h03);
    check(perf, 2'h3);
    @(posedge i_mclk) i_reset <= 1'b1;
    @(posedge i_mclk) i_reset <= 1'b0;
    tick(4);
    check(perf, 2'h0);
  endtask
  task automatic t_power();
    logic [2:0] mode [4] = '{3'b000, 3'b100, 3'b101, 3'b111};
    logic [1:0] seen;
    @(posedge i_mclk);
    smp_a <= 14'h0aaa;
    smp_b <= 14'h0555;
    foreach (mode[i]) begin
      @(posedge i_mclk) pm <= mode[i];
      tick(6);
      check(pdn, i == 1);
      check(stby, i == 2);
      if (i == 0 || i == 3) check(oe_a, i == 0);
    end
    seen = 2'b00;
    repeat (4) begin
      @(i_mclk) #5 seen |= {bus_b === 14'h0aaa, bus_b === 14'h0555};
    end
    check(seen, 2'b11);
    @(posedge i_mclk) pm <= 3'b000;
  endtask
  task automatic t_format();
    logic ob;
    logic [13:0] raw;
    logic [6:0] ev, od;
    raw = 14'h1234;
    @(posedge i_mclk);
    // reset pin held high: pin mode
    i_reset <= 1'b1;
    smp_a <= raw;
    smp_b <= raw;
    for (int f = 0; f < 4; f++) begin
      for (int o = 0; o < 3; o++) begin
        @(posedge i_mclk);
        fmt <= 2'(f);
        {op_a, op_b} <= {2{o == 1}};
        {on_a, on_b} <= {2{o == 2}};
        tick(6);
        ob = (f == 1 || f == 2);
        want = (o == 1) ? (ob ? 14'h3fff : 14'h1fff) : (o == 2) ? (ob ? 14'h0000 : 14'h2000) : raw ^ {ob, 13'h0};
        check(bus_a, want);
        check(bus_b, want);
        check(lvds, f >= 2);
        for (int k = 0; k < 7; k++) begin
          ev[k] = want[2 * k];
          od[k] = want[2 * k + 1];
        end
        if (f >= 2) begin
          @(posedge i_mclk) #5 check(pr_a, ev);
          @(negedge i_mclk) #5 check(pr_a, od);
        end
      end
    end
    @(posedge i_mclk);
    i_reset <= 1'b0;
    {op_a, op_b, on_a, on_b} <= 4'h0;
    tick(4);
    wr(acf_pkg::ADDR_FORMAT, 8'h18);
    check(bus_a, raw ^ 14'h2000);
  endtask
  initial begin
    i_reset = 1'b1;
    fmt = 2'h0;
    pm = 3'b000;
    smp_a = 14'h0000;
    smp_b = 14'h0000;
    {op_a, on_a, op_b, on_b} = 4'h0;
    oe_seen = 1'b0;
    n_errors = 0;
    compares = 0;
    cycles = 0;
    tick(5);
    i_reset <= 1'b0;
    tick(4);
    t_defaults();
    t_perf();
    t_swing();
    t_readback();
    t_resets();
    t_power();
    t_format();
    end_sim();
  end
endmodule
